// *** logic/adc_ctrl_consts.svh ***
// Constants for the converter control and result formatting block
`ifndef ADC_CTRL_CONSTS_SVH
`define ADC_CTRL_CONSTS_SVH
`define ADDR_CONTROL 4'h0
`define ADDR_STATUS 4'h1
`define ADDR_RESULT_HIGH 4'h2
`define ADDR_RESULT_LOW 4'h3
`define CTRL_RESET 8'h00
`define RESULT_RESET 16'h0000
`define RDATA_IDLE 8'h00
`define DIV_RESET 5'h00
`define BIT_POWER 7
`define BIT_JUSTIFY 6
`define BIT_LOW_RESOLUTION_SELECT 5
`define BIT_SIGNED 4
`define BIT_DONE 7
`define SAR_BITS 4'hA
`endif

// *** logic/adc_ctrl_pkg.sv ***
// Types for the converter control and result formatting block
package adc_ctrl_pkg;
    typedef struct packed {
        logic converter_power_on;
        logic justify_right;
        logic low_resolution_select;
        logic signed_output;
        logic [3:0] clock_divide_select;
    } control_s;
    typedef struct packed {
        logic [7:0] high;
        logic [7:0] low;
    } result_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONVERT = 3'b010,
        ST_DONE = 3'b100
    } conv_state_e;
endpackage

// *** logic/adc_ctrl.sv ***
// Converter control register, conversion sequencer and result formatter
//
// How it works
// - Control write aborts conversion, starts none
// - Bit 7 powers converter; clear aborts
// - Bit 6 picks left or right justify
// - 8-bit: justify only gates signed mode, low byte zero
// - Bit 5 selects 8-bit, bits 9-2 high
// - Bit 4 signed: invert result MSB
// - Signed only when left justified
// - Signed ranges follow from MSB inversion
// - Conversion clock is bus/((code+1)*2)
// - 10-bit left full scale FF:C0
// - 10-bit right full scale 03:FF
// - 8-bit signed full scale 7F, zero 80
// - Status write clears flag, starts conversion only if bit 7 set
// - Reset powers down, clears registers
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/1ns
`include "adc_ctrl_consts.svh"
module adc_ctrl
    import adc_ctrl_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic write_i,
    input wire logic read_i,
    input wire logic [9:0] sample_i,
    output logic [7:0] rdata_o,
    output logic conv_clk_o,
    output logic sample_start_o,
    output logic converter_power_on_o
);

    // ------------------------------------------------------------
    // Formatting function
    // ------------------------------------------------------------
    function automatic result_s format_result(input control_s c, input logic [9:0] r);
        result_s f;
        logic [9:0] v;
        v = r;
        if (!c.justify_right && c.signed_output) begin
            v[9] = ~r[9];
        end
        if (c.low_resolution_select) begin
            f.high = v[9:2];
            f.low = 8'h00;
        end else if (c.justify_right) begin
            f.high = {6'h00, r[9:8]};
            f.low = r[7:0];
        end else begin
            f.high = v[9:2];
            f.low = {v[1:0], 6'h00};
        end
        return f;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    control_s control, next_control;
    result_s result, next_result;
    conv_state_e state, next_state;
    logic done_flag, next_done_flag;
    logic [4:0] div_count, next_div_count;
    logic conv_clk, next_conv_clk;
    logic [3:0] bit_count, next_bit_count;
    logic [7:0] rdata, next_rdata;
    logic start, next_start;
    logic [9:0] sample_meta, sample_sync;
    logic [4:0] div_limit;
    logic tick;

    assign div_limit = {1'b0, control.clock_divide_select};
    assign tick = (div_count >= div_limit) && conv_clk;

    // ------------------------------------------------------------
    // Conversion clock divider
    // ------------------------------------------------------------
    always_comb begin
        next_div_count = div_count;
        next_conv_clk = conv_clk;
        if (!control.converter_power_on) begin
            next_div_count = `DIV_RESET;
            next_conv_clk = 1'b0;
        end else if (div_count >= div_limit) begin
            next_div_count = `DIV_RESET;
            next_conv_clk = ~conv_clk;
        end else begin
            next_div_count = div_count + 5'h01;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            div_count <= `DIV_RESET;
            conv_clk <= 1'b0;
        end else begin
            div_count <= next_div_count;
            conv_clk <= next_conv_clk;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and control, next values
    // ------------------------------------------------------------
    always_comb begin
        next_control = control;
        next_result = result;
        next_state = state;
        next_done_flag = done_flag;
        next_bit_count = bit_count;
        next_start = 1'b0;
        case (state)
            ST_IDLE: begin
                next_state = ST_IDLE;
            end
            ST_CONVERT: begin
                if (tick) begin
                    if (bit_count == `SAR_BITS) begin
                        next_state = ST_DONE;
                    end else begin
                        next_bit_count = bit_count + 4'h1;
                    end
                end
            end
            ST_DONE: begin
                next_result = format_result(control, sample_sync);
                next_done_flag = 1'b1;
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
        // Result read clears flag, completion wins
        if (read_i && (addr_i == `ADDR_RESULT_HIGH || addr_i == `ADDR_RESULT_LOW)) begin
            next_done_flag = (state == ST_DONE);
        end
        if (write_i) begin
            if (addr_i == `ADDR_CONTROL) begin
                next_control = wdata_i;
                next_state = ST_IDLE;
            end
            if (addr_i == `ADDR_STATUS) begin
                next_done_flag = (state == ST_DONE);
                if (control.converter_power_on) begin
                    next_state = ST_CONVERT;
                    next_bit_count = 4'h0;
                    next_start = 1'b1;
                end
            end
        end
        if (!next_control.converter_power_on) begin
            next_state = ST_IDLE;
            next_start = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Sequencer and control registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            control <= `CTRL_RESET;
            result <= `RESULT_RESET;
            state <= ST_IDLE;
            done_flag <= 1'b0;
            bit_count <= 4'h0;
            start <= 1'b0;
        end else begin
            control <= next_control;
            result <= next_result;
            state <= next_state;
            done_flag <= next_done_flag;
            bit_count <= next_bit_count;
            start <= next_start;
        end
    end

    // ------------------------------------------------------------
    // Sample synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_i) begin
        sample_meta <= sample_i;
        sample_sync <= sample_meta;
    end

    // ------------------------------------------------------------
    // Register readback
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = `RDATA_IDLE;
        if (read_i) begin
            case (addr_i)
                `ADDR_CONTROL: next_rdata = control;
                `ADDR_STATUS: next_rdata = {done_flag, 7'h00};
                `ADDR_RESULT_HIGH: next_rdata = result.high;
                `ADDR_RESULT_LOW: next_rdata = result.low;
                default: next_rdata = `RDATA_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!reset_n_i) begin
            rdata <= `RDATA_IDLE;
        end else begin
            rdata <= next_rdata;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rdata_o = rdata;
    assign conv_clk_o = conv_clk;
    assign sample_start_o = start;
    assign converter_power_on_o = control.converter_power_on;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_ctrl_write_abort: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        write_i && addr_i == `ADDR_CONTROL |=> state == ST_IDLE && !start)
        else $error("control write did not abort");
    chk_power_off_idle: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !control.converter_power_on |-> state == ST_IDLE)
        else $error("converter active while powered down");
    chk_power_off_clock: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        !control.converter_power_on |=> !conv_clk)
        else $error("conversion clock runs while powered down");
    chk_left_placement: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && !control.justify_right && !control.low_resolution_select
        && !control.signed_output |=> result == {$past(sample_sync), 6'h00})
        else $error("left justified result wrong");
    chk_low_resolution_select_low_zero: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && control.low_resolution_select |=> result.low == 8'h00)
        else $error("8-bit low byte not zero");
    chk_low_resolution_select_high: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && control.low_resolution_select
        && (control.justify_right || !control.signed_output)
        |=> result.high == $past(sample_sync[9:2]))
        else $error("8-bit high byte wrong");
    chk_signed_msb: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && !control.justify_right && control.signed_output
        |=> result.high[7] == ~$past(sample_sync[9]))
        else $error("signed MSB not inverted");
    chk_right_unsigned: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && !control.low_resolution_select && control.justify_right
        |=> result == {6'h00, $past(sample_sync)})
        else $error("right justified result wrong");
    chk_signed_rest: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && !control.justify_right && control.signed_output
        && !control.low_resolution_select |=> result.high[6:0] == $past(sample_sync[8:2]))
        else $error("signed result body wrong");
    chk_divider_half: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        $rose(conv_clk) && $stable(control) && control.clock_divide_select == 4'h0
        |=> $fell(conv_clk))
        else $error("divide by two wrong");
    chk_divider_bound: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        control.converter_power_on && $stable(control) |-> div_count <= div_limit)
        else $error("divider count beyond limit");
    chk_left_low_bits: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && !control.justify_right |=> result.low[5:0] == 6'h00)
        else $error("left justified low bits not zero");
    chk_right_high_zero: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && control.justify_right && !control.low_resolution_select
        |=> result.high[7:2] == 6'h00)
        else $error("right justified high bits not zero");
    chk_low_resolution_select_signed: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE && control.low_resolution_select && !control.justify_right
        && control.signed_output
        |=> result.high == {~$past(sample_sync[9]), $past(sample_sync[8:2])})
        else $error("8-bit signed result wrong");
    chk_status_start: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        write_i && addr_i == `ADDR_STATUS && control.converter_power_on && state != ST_DONE
        |=> start && !done_flag && state == ST_CONVERT)
        else $error("status write did not start");
    chk_start_converts: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        start |-> state == ST_CONVERT)
        else $error("start pulse without conversion");
    chk_reset_state: assert property (
        @(posedge clk_sys_i)
        !reset_n_i |=> control == `CTRL_RESET && state == ST_IDLE && !done_flag && !conv_clk)
        else $error("reset state wrong");
    chk_done_flag_set: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state == ST_DONE |=> done_flag)
        else $error("done flag not set at completion");
    chk_result_hold: assert property (
        @(posedge clk_sys_i) disable iff (!reset_n_i)
        state != ST_DONE |=> $stable(result))
        else $error("result changed without completion");
endmodule

// *** testbench/analog_core_model.sv ***
// Behavioural model of the analog sampling core
`timescale 1ns/1ns
module analog_core_model (
    input wire logic clk_sys_i,
    input wire logic start_i,
    input wire logic [9:0] level_i,
    output logic [9:0] sample_o
);
    logic [9:0] held;
    // Capture level at start, then settle
    always_ff @(posedge clk_sys_i) begin
        if (start_i) held <= level_i;
        sample_o <= held;
    end
endmodule

// *** testbench/adc_control_result_format_bench.sv ***
// Self-checking bench for the converter control block
`timescale 1ns/1ns
module adc_control_result_format_bench;
    logic clk_sys_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [3:0] addr_i = 4'h0;
    logic [7:0] wdata_i = 8'h00;
    logic write_i = 1'b0;
    logic read_i = 1'b0;
    logic [9:0] level = 10'h000;
    logic [9:0] sample_i;
    logic [7:0] rdata_o, rd;
    logic conv_clk_o, sample_start_o, converter_power_on_o, prev_clk;
    int errors = 0;
    int n_tests = 0;
    int starts = 0;
    int s0;
    // ------------------------------------------------
    // Clock, design and partner
    // ------------------------------------------------
    initial begin
        forever #4 clk_sys_i = ~clk_sys_i;
    end
    adc_ctrl uut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .write_i(write_i), .read_i(read_i), .sample_i(sample_i),
        .rdata_o(rdata_o), .conv_clk_o(conv_clk_o), .sample_start_o(sample_start_o),
        .converter_power_on_o(converter_power_on_o));
    analog_core_model core (.clk_sys_i(clk_sys_i), .start_i(sample_start_o),
        .level_i(level), .sample_o(sample_i));
    always @(posedge clk_sys_i) begin
        prev_clk <= conv_clk_o;
        if (sample_start_o === 1'b1) starts <= starts + 1;
    end
    // ------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        write_i <= 1'b1;
        @(posedge clk_sys_i);
        write_i <= 1'b0;
    endtask
    task automatic rdreg(input logic [3:0] a);
        @(posedge clk_sys_i);
        addr_i <= a;
        read_i <= 1'b1;
        @(posedge clk_sys_i);
        read_i <= 1'b0;
        #1;
        rd = rdata_o;
    endtask
    task automatic wait_done();
        for (int i = 0; i < 250; i++) begin
            rdreg(4'h1);
            if (rd[7] === 1'b1) break;
        end
        chk(rd, 8'h80);
    endtask
    task automatic conv(input logic [7:0] c, input logic [9:0] lv, input logic [7:0] hi,
                        input logic [7:0] lo);
        level = lv;
        wr(4'h0, {c[7:4], 4'hF});
        wr(4'h1, 8'h00);
        wait_done();
        rdreg(4'h2);
        chk(rd, hi);
        rdreg(4'h3);
        chk(rd, lo);
    endtask
    task automatic period(input logic [3:0] code);
        int n;
        n = 0;
        wr(4'h0, {4'h8, code});
        for (int i = 0; i < 200 && n < 2; i++) begin
            @(posedge clk_sys_i);
            #1;
            if (conv_clk_o === 1'b1 && prev_clk === 1'b0) n++;
        end
        n = 0;
        do begin
            @(posedge clk_sys_i);
            #1;
            n++;
        end while (!(conv_clk_o === 1'b1 && prev_clk === 1'b0) && n < 100);
        chk(8'(n), 8'((code + 1) * 2));
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // ------------------------------------------------
    // Test sequence
    // ------------------------------------------------
    initial begin
        #100000;
        errors++;
        tally_and_finish();
    end
    initial begin
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rdreg(4'h0);
        chk(rd, 8'h00);
        chk({7'h00, converter_power_on_o}, 8'h00);
        rdreg(4'hF);
        chk(rd, 8'h00);
        s0 = starts;
        wr(4'h1, 8'h00);
        repeat (40) @(posedge clk_sys_i);
        chk(8'(starts - s0), 8'h00);
        conv(8'h80, 10'h3FF, 8'hFF, 8'hC0);
        conv(8'h80, 10'h2A5, 8'hA9, 8'h40);
        conv(8'h90, 10'h3FF, 8'h7F, 8'hC0);
        conv(8'h90, 10'h000, 8'h80, 8'h00);
        conv(8'hC0, 10'h3FF, 8'h03, 8'hFF);
        conv(8'hC0, 10'h000, 8'h00, 8'h00);
        conv(8'hD0, 10'h2A5, 8'h02, 8'hA5);
        conv(8'hA0, 10'h2A5, 8'hA9, 8'h00);
        conv(8'hB0, 10'h3FF, 8'h7F, 8'h00);
        conv(8'hB0, 10'h000, 8'h80, 8'h00);
        conv(8'hE0, 10'h3FF, 8'hFF, 8'h00);
        conv(8'hF0, 10'h3FF, 8'hFF, 8'h00);
        wr(4'h0, 8'hC0);
        rdreg(4'h2);
        chk(rd, 8'hFF);
        chk({7'h00, converter_power_on_o}, 8'h01);
        s0 = starts;
        wr(4'h1, 8'h00);
        wait_done();
        chk(8'(starts - s0), 8'h01);
        wr(4'h2, 8'h55);
        wr(4'h1, 8'h00);
        rdreg(4'h1);
        chk(rd, 8'h00);
        rdreg(4'h2);
        chk(rd, 8'h03);
        s0 = starts;
        wr(4'h0, 8'h80);
        repeat (60) @(posedge clk_sys_i);
        rdreg(4'h1);
        chk(rd, 8'h00);
        chk(8'(starts - s0), 8'h00);
        wr(4'h1, 8'h00);
        repeat (4) @(posedge clk_sys_i);
        wr(4'h0, 8'h00);
        repeat (60) @(posedge clk_sys_i);
        rdreg(4'h1);
        chk(rd, 8'h00);
        chk({7'h00, converter_power_on_o}, 8'h00);
        for (int c = 0; c < 16; c += 5) begin
            period(4'(c));
        end
        tally_and_finish();
    end
endmodule
